/* common/dwd_pkg.sv */
// constants, types and address map of the dac write decoder
package dwd_pkg;

	// ----------------------------------------------------------------
	// channel and data geometry
	// ----------------------------------------------------------------
	localparam int DWD_DATA_W = 14;
	localparam int DWD_ADDR_W = 8;
	localparam int DWD_NUM_CH = 32;
	localparam int DWD_GRP_SIZE = 8;
	localparam int DWD_NUM_GRP = 4;
	localparam int DWD_STEP_W = 7;
	localparam int DWD_DIR_BIT = 8;
	localparam int DWD_STEP_HI = 6;
	localparam int DWD_ZERO_HI = 13;
	localparam int DWD_ZERO_LO = 9;
	localparam logic [13:0] DWD_FULL_SCALE = 14'h3fff;
	localparam logic [13:0] DWD_ZERO_SCALE = 14'h0000;
	localparam logic [13:0] DWD_SOFT_RESET = 14'h3fff;

	// ----------------------------------------------------------------
	// power-on register values
	// ----------------------------------------------------------------
	localparam logic [13:0] DWD_INPUT_RST = 14'h0000;
	localparam logic [13:0] DWD_OFFSET_RST = 14'h2000;
	localparam logic [13:0] DWD_GAIN_RST = 14'h3fff;

	// ----------------------------------------------------------------
	// address field decode
	// ----------------------------------------------------------------
	localparam int DWD_GRP_HI = 7;
	localparam int DWD_GRP_LO = 4;
	localparam int DWD_IDX_HI = 3;
	localparam logic [3:0] DWD_GRP_ALL = 4'h0;
	localparam logic [3:0] DWD_IDX_6_CODE = 4'h8;
	localparam logic [3:0] DWD_IDX_7_CODE = 4'h9;
	localparam logic [3:0] DWD_IDX_5_CODE = 4'h5;

	// ----------------------------------------------------------------
	// ahb-lite register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] DWD_INPUT_BASE = 12'h000;
	localparam logic [11:0] DWD_OFFSET_BASE = 12'h080;
	localparam logic [11:0] DWD_GAIN_BASE = 12'h100;
	localparam logic [11:0] DWD_STATUS_ADDR = 12'h180;
	localparam logic [11:0] DWD_CTRL_ADDR = 12'h184;
	localparam logic [1:0] DWD_BANK_INPUT = 2'h0;
	localparam logic [1:0] DWD_BANK_OFFSET = 2'h1;
	localparam logic [1:0] DWD_BANK_GAIN = 2'h2;
	localparam logic [1:0] DWD_BANK_MISC = 2'h3;
	localparam int DWD_GND_BIT = 0;
	localparam int DWD_CNT_LO = 8;
	localparam int DWD_CNT_W = 8;
	localparam logic [1:0] DWD_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] DWD_HRESP_OKAY = 2'h0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DWD_TGT_SPECIAL = 2'b00,
		DWD_TGT_GAIN = 2'b01,
		DWD_TGT_OFFSET = 2'b10,
		DWD_TGT_INPUT = 2'b11
	} dwd_target_type;

	typedef struct packed {
		logic [1:0] target;
		logic [7:0] addr;
		logic [13:0] data;
	} dwd_cmd_type;

endpackage

/* src/dwd_step_unit.sv */
// saturating increment/decrement of one channel input value
`timescale 1ns/1ns
module dwd_step_unit
	import dwd_pkg::*;
#(
	parameter int DATA_W = 14,
	parameter int STEP_W = 7
) (
	input wire logic [DATA_W-1:0] i_value,
	input wire logic i_up,
	input wire logic [STEP_W-1:0] i_step,
	output logic [DATA_W-1:0] o_result
);

	logic [DATA_W:0] sum_w;
	logic [DATA_W:0] diff_w;

	// one extra bit catches carry out and borrow
	always_comb begin
		sum_w = {1'b0, i_value} + {{(DATA_W+1-STEP_W){1'b0}}, i_step};
		diff_w = {1'b0, i_value} - {{(DATA_W+1-STEP_W){1'b0}}, i_step};
		if (i_up) begin
			o_result = sum_w[DATA_W] ? {DATA_W{1'b1}} : sum_w[DATA_W-1:0]; // [R14]
		end else begin
			o_result = diff_w[DATA_W] ? {DATA_W{1'b0}} : diff_w[DATA_W-1:0]; // [R14]
		end
	end

endmodule

/* src/dwd_top.sv */
// write decoder for a 32-channel dac with ahb-lite readback
// Functional notes
// R01: 14-bit word routed by two target bits
// R02: select 11 stores input channel code
// R03: select 10 stores offset correction code
// R04: select 01 stores gain code
// R05: select 00: bit8 direction, bits6..0 step
// R06: zero step leaves input value unchanged
// R07: special all-ones word performs soft reset
// R08: 8-bit address reaches every register
// R09: upper nibble selects groups, zero all
// R10: all-channel code ignores lower nibble
// R11: lower nibble picks index, 8/9 give 6/7
// R12: unlisted index codes change nothing
// R13: fields captured on strobe rise, select low
// R14: increment/decrement clamps at full or zero
`timescale 1ns/1ns
module dwd_top
	import dwd_pkg::*;
#(
	parameter int NUM_CH = 32,
	parameter int GRP_SIZE = 8
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	// parallel write port
	input wire logic i_cs_n,
	input wire logic i_wr_n,
	input wire logic [1:0] i_target_sel,
	input wire logic [7:0] i_addr,
	input wire logic [13:0] i_data_word_bits,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// outputs held at reference ground
	output logic o_reference_ground_r
);
	// package constants and types
	import dwd_pkg::*;

	// ----------------------------------------------------------------
	// pin capture and strobe edge detect
	// ----------------------------------------------------------------
	// sampled fields and previous strobe levels
	dwd_cmd_type cmd_r;
	logic wr_n_r;
	logic cs_n_r;
	logic strobe_rise;

	// hold the previous pin levels so a rising strobe uses stable fields
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_n_r <= 1'b1;
			cs_n_r <= 1'b1;
			cmd_r <= '0;
		end else begin
			wr_n_r <= i_wr_n;
			cs_n_r <= i_cs_n;
			cmd_r.target <= i_target_sel;
			cmd_r.addr <= i_addr;
			cmd_r.data <= i_data_word_bits;
		end
	end

	// strobe low-to-high with device select low in the last strobe-low sample, the cycle before the rise
	assign strobe_rise = !wr_n_r && i_wr_n && !cs_n_r; // [R13]

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// decoded address fields and per-channel hits
	logic [3:0] group_select_field;
	logic [3:0] register_index_field;
	logic all_channels;
	logic index_valid;
	logic [2:0] index_num;
	logic [NUM_CH-1:0] ch_sel;

	// split the captured address into group and index
	assign group_select_field = cmd_r.addr[DWD_GRP_HI:DWD_GRP_LO]; // [R08]
	assign register_index_field = cmd_r.addr[DWD_IDX_HI:0];
	assign all_channels = (group_select_field == DWD_GRP_ALL); // [R09]

	// index code to register number; gaps are invalid
	always_comb begin
		index_valid = 1'b0;
		index_num = 3'h0;
		if (register_index_field <= DWD_IDX_5_CODE) begin
			index_valid = 1'b1;
			index_num = register_index_field[2:0]; // [R11]
		end else if (register_index_field == DWD_IDX_6_CODE) begin
			index_valid = 1'b1;
			index_num = 3'h6; // [R11]
		end else if (register_index_field == DWD_IDX_7_CODE) begin
			index_valid = 1'b1;
			index_num = 3'h7; // [R11]
		end else begin
			index_valid = 1'b0; // [R12]
			index_num = 3'h0;
		end
	end

	// per-channel hit: all channels, or named group and matching index
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CH; gc++) begin : g_sel
			localparam int GRP = gc / GRP_SIZE;
			localparam logic [2:0] IDX = 3'(gc % GRP_SIZE);
			// lower nibble ignored for the all-channel code
			assign ch_sel[gc] = all_channels || // [R10]
				(group_select_field[GRP] && index_valid && index_num == IDX); // [R09] [R12]
		end
	endgenerate

	// ----------------------------------------------------------------
	// command classification
	// ----------------------------------------------------------------
	// one-cycle command strobes
	logic do_input;
	logic do_offset;
	logic do_gain;
	logic do_soft_reset;
	logic do_step;
	logic step_up;
	logic [DWD_STEP_W-1:0] step_size;

	// target bits route the data word
	always_comb begin
		do_input = 1'b0;
		do_offset = 1'b0;
		do_gain = 1'b0;
		do_soft_reset = 1'b0;
		do_step = 1'b0;
		if (strobe_rise) begin
			case (dwd_target_type'(cmd_r.target))
				DWD_TGT_INPUT: begin
					do_input = 1'b1; // [R01] [R02]
				end
				DWD_TGT_OFFSET: begin
					do_offset = 1'b1; // [R01] [R03]
				end
				DWD_TGT_GAIN: begin
					do_gain = 1'b1; // [R01] [R04]
				end
				DWD_TGT_SPECIAL: begin
					if (cmd_r.data == DWD_SOFT_RESET) begin
						do_soft_reset = 1'b1; // [R07]
					end else if (cmd_r.data[DWD_ZERO_HI:DWD_ZERO_LO] == 5'h00) begin
						do_step = 1'b1; // [R05]
					end
				end
				default: begin
					do_input = 1'b0;
				end
			endcase
		end
	end

	// direction and step size of a special word
	assign step_up = cmd_r.data[DWD_DIR_BIT]; // [R05]
	assign step_size = cmd_r.data[DWD_STEP_HI:0]; // [R05]

	// ----------------------------------------------------------------
	// channel registers
	// ----------------------------------------------------------------
	// per-channel input, offset and gain storage
	logic [DWD_DATA_W-1:0] input_r [NUM_CH];
	logic [DWD_DATA_W-1:0] offset_r [NUM_CH];
	logic [DWD_DATA_W-1:0] gain_r [NUM_CH];

	// one register set and step unit per channel
	genvar gr;
	generate
		for (gr = 0; gr < NUM_CH; gr++) begin : g_ch
			logic [DWD_DATA_W-1:0] stepped;

			// saturating step of this channel's input value
			dwd_step_unit #(
				.DATA_W(DWD_DATA_W),
				.STEP_W(DWD_STEP_W)
			) u_step (
				.i_value(input_r[gr]),
				.i_up(step_up),
				.i_step(step_size),
				.o_result(stepped)
			);

			// channel input value: direct load or step
			always_ff @(posedge i_mclk or negedge i_resetn) begin
				if (!i_resetn) begin
					input_r[gr] <= DWD_INPUT_RST;
				end else if (do_soft_reset) begin
					input_r[gr] <= DWD_INPUT_RST; // [R07]
				end else if (do_input && ch_sel[gr]) begin
					input_r[gr] <= cmd_r.data; // [R02]
				end else if (do_step && ch_sel[gr] && step_size != '0) begin
					input_r[gr] <= stepped; // [R05] [R06] [R14]
				end
			end

			// offset correction code, all-ones most positive
			always_ff @(posedge i_mclk or negedge i_resetn) begin
				if (!i_resetn) begin
					offset_r[gr] <= DWD_OFFSET_RST;
				end else if (do_soft_reset) begin
					offset_r[gr] <= DWD_OFFSET_RST; // [R07]
				end else if (do_offset && ch_sel[gr]) begin
					offset_r[gr] <= cmd_r.data; // [R03]
				end
			end

			// gain code, all-ones unity
			always_ff @(posedge i_mclk or negedge i_resetn) begin
				if (!i_resetn) begin
					gain_r[gr] <= DWD_GAIN_RST;
				end else if (do_soft_reset) begin
					gain_r[gr] <= DWD_GAIN_RST; // [R07]
				end else if (do_gain && ch_sel[gr]) begin
					gain_r[gr] <= cmd_r.data; // [R04]
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// status: ground flag and write counter
	// ----------------------------------------------------------------
	// ground clear request and strobe counter
	logic gnd_clear;
	logic [DWD_CNT_W-1:0] write_cnt_r;

	// soft reset grounds outputs; set wins over software clear
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_reference_ground_r <= 1'b1;
		end else if (do_soft_reset) begin
			o_reference_ground_r <= 1'b1; // [R07]
		end else if (gnd_clear) begin
			o_reference_ground_r <= 1'b0;
		end
	end

	// counts every accepted strobe edge, wraps
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			write_cnt_r <= '0;
		end else if (strobe_rise) begin
			write_cnt_r <= write_cnt_r + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// ----------------------------------------------------------------
	// address phase capture and read mux signals
	logic ahb_take;
	logic wr_pend_r;
	logic [11:0] wr_addr_r;
	logic [11:0] rd_addr;
	logic [1:0] rd_bank;
	logic [4:0] rd_idx;
	logic rd_mapped;
	logic [31:0] rd_word;

	// accepted address phase, read decode and clear request
	assign ahb_take = i_hsel && i_hready && (i_htrans == DWD_HTRANS_NONSEQ);
	assign rd_addr = i_haddr[11:0];
	assign rd_bank = rd_addr[8:7];
	assign rd_idx = rd_addr[6:2];
	assign rd_mapped = (i_haddr[31:9] == '0);
	assign gnd_clear = wr_pend_r && (wr_addr_r == DWD_CTRL_ADDR) && i_hwdata[DWD_GND_BIT];

	// remember a write address phase for its data phase
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
		end else if (i_hready) begin
			wr_pend_r <= ahb_take && i_hwrite;
			wr_addr_r <= rd_addr;
		end
	end

	// read word selection; unmapped reads return zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (rd_mapped) begin
			case (rd_bank)
				DWD_BANK_INPUT: begin
					rd_word = {18'h00000, input_r[rd_idx]};
				end
				DWD_BANK_OFFSET: begin
					rd_word = {18'h00000, offset_r[rd_idx]};
				end
				DWD_BANK_GAIN: begin
					rd_word = {18'h00000, gain_r[rd_idx]};
				end
				DWD_BANK_MISC: begin
					if (rd_addr == DWD_STATUS_ADDR) begin
						rd_word = {16'h0000, write_cnt_r, 7'h00, o_reference_ground_r};
					end
				end
				default: begin
					rd_word = 32'h0000_0000;
				end
			endcase
		end
	end

	// read data registered at the address phase edge
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_hrdata <= 32'h0000_0000;
		end else if (ahb_take && !i_hwrite) begin
			o_hrdata <= rd_word;
		end
	end

	// always ready: zero wait states
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_hreadyout <= 1'b1;
		end else begin
			o_hreadyout <= 1'b1;
		end
	end

	// always okay: no transfer is refused
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_hresp <= 1'b0;
		end else begin
			o_hresp <= DWD_HRESP_OKAY[0];
		end
	end

endmodule

/* tb/dac_write_decoder_bench.sv */
// self-checking bench of the dac write decoder
`timescale 1ns/1ns
module dac_write_decoder_bench;
	import dwd_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [15:0] rnd = 16'h0032;
	logic [13:0] m_in [32];
	logic [13:0] m_off [32];
	logic [13:0] m_gain [32];
	logic m_gnd;
	logic [7:0] m_cnt = 8'h00;
	int n_errors = 0;
	int n_tests = 0;
	wire logic cs_n;
	wire logic wr_n;
	wire logic [31:0] hrdata;
	wire logic hreadyout;
	wire logic hresp;
	wire logic gnd_pin;
	dwd_cmd_type cmd;
	dwd_cmd_type corner [17] = '{'{2'h3, 8'h00, 14'h1234}, '{2'h3, 8'h13, 14'h2222}, '{2'h3, 8'h16, 14'h0abc},
		'{2'h2, 8'hf8, 14'h0001}, '{2'h1, 8'h29, 14'h0000}, '{2'h3, 8'h5f, 14'h0aaa}, '{2'h0, 8'h00, 14'h017f},
		'{2'h0, 8'h00, 14'h0100}, '{2'h0, 8'h00, 14'h0000}, '{2'h0, 8'h11, 14'h0005}, '{2'h0, 8'h00, 14'h0201},
		'{2'h3, 8'h00, 14'h3ff0}, '{2'h0, 8'h00, 14'h017f}, '{2'h0, 8'h00, 14'h007f}, '{2'h3, 8'h00, 14'h0005},
		'{2'h0, 8'h00, 14'h007f}, '{2'h0, 8'h00, 14'h3fff}};
	dwd_cmd_type hcmd;
	always #5 mclk = ~mclk;
	dwd_host_model i_host(.i_mclk(mclk), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_cmd(hcmd));
	dwd_top i_dut(.i_mclk(mclk), .i_resetn(resetn), .i_cs_n(cs_n), .i_wr_n(wr_n), .i_target_sel(hcmd.target),
		.i_addr(hcmd.addr), .i_data_word_bits(hcmd.data), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .o_reference_ground_r(gnd_pin));
	// ----------------------------------------------------------------
	// expectation functions
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] chmask(input logic [7:0] a);
		logic [3:0] idx;
		chmask = 32'h0;
		if (a[7:4] == DWD_GRP_ALL)
			return 32'hffffffff;
		idx = (a[3:0] <= DWD_IDX_5_CODE) ? a[3:0] : (a[3:0] == DWD_IDX_6_CODE) ? 4'h6 :
			(a[3:0] == DWD_IDX_7_CODE) ? 4'h7 : 4'hf;
		for (int g = 0; g < 4; g++)
			if (a[4 + g] && idx != 4'hf)
				chmask[g * 8 + idx] = 1'b1;
	endfunction
	function automatic logic [13:0] stepf(input logic [13:0] v, input logic up, input logic [6:0] s);
		logic [14:0] t;
		t = up ? {1'b0, v} + s : {1'b0, v} - s;
		if (t[14])
			return up ? DWD_FULL_SCALE : DWD_ZERO_SCALE;
		return t[13:0];
	endfunction
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task give_verdict;
		if (n_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= DWD_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task reset_model;
		for (int c = 0; c < 32; c++) begin
			m_in[c] = DWD_INPUT_RST;
			m_off[c] = DWD_OFFSET_RST;
			m_gain[c] = DWD_GAIN_RST;
		end
		m_gnd = 1'b1;
	endtask
	task check_all;
		for (int b = 0; b < 3; b++)
			for (int c = 0; c < 32; c++) begin
				ahb(1'b0, 32'(b) * 32'h80 + 32'(c) * 32'h4, 32'h0);
				chk("register", rd, {18'h0, b == 0 ? m_in[c] : b == 1 ? m_off[c] : m_gain[c]});
			end
		ahb(1'b0, 32'h180, 32'h0);
		chk("status", rd, {16'h0, m_cnt, 7'h0, m_gnd});
		chk("ground pin", {31'h0, gnd_pin}, {31'h0, m_gnd});
		chk("response", {31'h0, hresp}, 32'h0);
	endtask
	task put(input dwd_cmd_type c);
		logic [31:0] m;
		i_host.send(c);
		m_cnt = m_cnt + 8'h01;
		m = chmask(c.addr);
		if (c.target == DWD_TGT_SPECIAL && c.data == DWD_SOFT_RESET)
			reset_model;
		else
			for (int k = 0; k < 32; k++)
				if (m[k])
					case (c.target)
						DWD_TGT_INPUT: m_in[k] = c.data;
						DWD_TGT_OFFSET: m_off[k] = c.data;
						DWD_TGT_GAIN: m_gain[k] = c.data;
						default: if (c.data[13:9] == 5'h0) m_in[k] = stepf(m_in[k], c.data[8], c.data[6:0]);
					endcase
		repeat (2) @(posedge mclk);
		check_all;
	endtask
	// ----------------------------------------------------------------
	// watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		give_verdict;
	end
	initial begin
		reset_model;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		check_all;
		ahb(1'b0, 32'h200, 32'h0);
		chk("unmapped", rd, 32'h0);
		ahb(1'b1, 32'h184, 32'h1);
		ahb(1'b1, 32'h100, 32'h55);
		m_gnd = 1'b0;
		check_all;
		foreach (corner[i])
			put(corner[i]);
		for (int i = 0; i < 24; i++) begin
			rnd = lfsr(rnd);
			cmd.target = rnd[1:0];
			rnd = lfsr(rnd);
			cmd.addr = rnd[7:0];
			rnd = lfsr(rnd);
			cmd.data = rnd[13:0];
			if (cmd.target == DWD_TGT_SPECIAL)
				cmd.data[13:7] = {5'h0, cmd.data[8], 1'b0};
			put(cmd);
		end
		give_verdict;
	end
endmodule

/* tb/dwd_host_model.sv */
// host model driving the parallel write port
`timescale 1ns/1ns
module dwd_host_model (
	input wire logic i_mclk,
	output logic o_cs_n,
	output logic o_wr_n,
	output dwd_pkg::dwd_cmd_type o_cmd
);
	import dwd_pkg::*;
	// idle: deselected
	initial begin
		o_cs_n = 1'b1;
		o_wr_n = 1'b1;
		o_cmd = '0;
	end
	// one write: fields held while selected, strobe rise commits
	task automatic send(input dwd_pkg::dwd_cmd_type c);
		@(posedge i_mclk);
		o_cs_n <= 1'b0;
		o_wr_n <= 1'b0;
		o_cmd <= c;
		@(posedge i_mclk);
		o_wr_n <= 1'b1;
		@(posedge i_mclk);
		o_cs_n <= 1'b1;
		o_cmd <= ~c; // released lines show no stale value
	endtask
endmodule

/* tb/dwd_top_props.sv */
// port checker of the dac write decoder
`timescale 1ns/1ns
module dwd_top_props
	import dwd_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_cs_n,
	input wire logic i_wr_n,
	input wire logic [1:0] i_target_sel,
	input wire logic [13:0] i_data_word_bits,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic o_reference_ground_r
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	logic sreset_q;
	logic ctl_q;
	wire logic take = i_hsel && i_hready && i_htrans == DWD_HTRANS_NONSEQ;
	wire logic sreset_now = !i_cs_n && !i_wr_n && i_target_sel == DWD_TGT_SPECIAL && i_data_word_bits == DWD_SOFT_RESET;
	wire logic soft_go = sreset_q && i_wr_n;
	// ----------------------------------------------------------------
	// helpers: strobe low phase and control write data phase
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			sreset_q <= 1'b0;
			ctl_q <= 1'b0;
		end else begin
			sreset_q <= sreset_now;
			ctl_q <= take && i_hwrite && i_haddr[11:0] == DWD_CTRL_ADDR;
		end
	end
	sequence soft_wr_s;
		sreset_now ##1 i_wr_n;
	endsequence
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	okay_resp_a: assert property (o_hresp == 1'b0) else $error("response not okay");
	ready_high_a: assert property (o_hreadyout) else $error("slave stalled");
	upper_zero_a: assert property (o_hrdata[31:16] == 16'h0) else $error("read data upper bits set");
	soft_ground_a: assert property (soft_wr_s |-> ##[1:2] o_reference_ground_r)
		else $error("soft reset did not ground outputs");
	ground_rise_a: assert property ($rose(o_reference_ground_r) |-> $past(soft_go) || $past(soft_go, 2))
		else $error("ground flag rose without soft reset");
	ground_fall_a: assert property ($fell(o_reference_ground_r) |-> $past(ctl_q && i_hwdata[DWD_GND_BIT]))
		else $error("ground flag cleared without control write");
	rdata_hold_a: assert property (!$past(take && !i_hwrite) |-> $stable(o_hrdata))
		else $error("read data changed without read");
	unmapped_zero_a: assert property (take && !i_hwrite && i_haddr >= 32'h184 |=> o_hrdata == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind dwd_top dwd_top_props i_props(.i_mclk, .i_resetn, .i_cs_n, .i_wr_n, .i_target_sel, .i_data_word_bits,
	.i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
	.o_reference_ground_r);
